// File: dv/card_host_model.sv
module card_host_model (
  input wire logic clk_sys_i,
  output logic read_req_o,
  output logic prog_o,
  output logic [127:0] data_o,
  input wire logic [127:0] read_data_i,
  input wire logic read_valid_i,
  input wire logic program_done_i,
  input wire logic [1:0] program_status_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    read_req_o = 1'b0;
    prog_o = 1'b0;
    data_o = '1;
  end
  // one-cycle pulse off the falling edge, answer sampled a cycle later
  task automatic xfer(input logic wr, input logic [127:0] p,
                      output logic [127:0] d, output logic ok,
                      output logic [1:0] s);
    @(negedge clk_sys_i);
    prog_o = wr;
    read_req_o = !wr;
    data_o = p;
    @(negedge clk_sys_i);
    prog_o = 1'b0;
    read_req_o = 1'b0;
    data_o = ~p; // stale data would hide a late sample
    d = read_data_i;
    ok = wr ? program_done_i : read_valid_i;
    s = program_status_i;
  endtask : xfer
endmodule : card_host_model

// File: dv/card_specific_data_register_props.sv
module card_specific_data_register_props #(
  parameter logic [11:0] DEVICE_SIZE = 12'hfff
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic read_req_i,
  input wire logic program_card_specific_i,
  input wire logic [127:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic program_done_o,
  input wire logic [1:0] program_status_o,
  input wire logic once_locked_o,
  input wire logic temp_protect_o,
  input wire logic perm_protect_o,
  input wire logic copy_flag_o,
  input wire logic file_group_o,
  input wire logic [1:0] file_format_o,
  input wire logic [1:0] ecc_type_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] views;
  assign views = {once_locked_o, file_group_o, copy_flag_o, perm_protect_o,
                  temp_protect_o, file_format_o, ecc_type_o};
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ****************
  // read image
  // ****************
  AST_READ_ANSWER: assert property (read_req_i |=> read_valid_o)
    else $error("read answer missing");
  AST_TIMING: assert property (read_valid_o |->
    read_data_o[119:96] == 24'h4f0132) else $error("timing fields wrong");
  AST_READ_BLOCK: assert property (read_valid_o |->
    read_data_o[83:76] == 8'h90) else $error("read block fields wrong");
  AST_GROUPS: assert property (read_valid_o |->
    read_data_o[46:31] == 16'hffff) else $error("group fields wrong");
  AST_WRITE_BLOCK: assert property (read_valid_o |->
    read_data_o[25:21] == 5'h12) else $error("write block fields wrong");
  AST_RESERVED: assert property (read_valid_o |->
    read_data_o[121:120] == 2'h0 && read_data_o[75:74] == 2'h0 &&
    read_data_o[20:17] == 4'h0 && read_data_o[73:62] == DEVICE_SIZE)
    else $error("reserved or size bits wrong");
  // ****************
  // programming
  // ****************
  AST_PROG_DONE: assert property (program_card_specific_i |=>
    program_done_o) else $error("program answer missing");
  AST_REFUSED_KEEP: assert property (program_done_o &&
    program_status_o != 2'h0 |=> $stable(views))
    else $error("refused program changed state");
  AST_LOCK_SET: assert property (program_done_o &&
    program_status_o == 2'h0 |=> once_locked_o) else $error("lock not set");
  AST_LOCK_HOLD: assert property (once_locked_o |=> once_locked_o)
    else $error("lock dropped");
endmodule : card_specific_data_register_props

bind card_specific_data_register card_specific_data_register_props #(
  .DEVICE_SIZE(DEVICE_SIZE)) u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .read_req_i(read_req_i), .program_card_specific_i(program_card_specific_i),
  .read_data_o(read_data_o), .read_valid_o(read_valid_o),
  .program_done_o(program_done_o), .program_status_o(program_status_o),
  .once_locked_o(once_locked_o), .temp_protect_o(temp_protect_o),
  .perm_protect_o(perm_protect_o), .copy_flag_o(copy_flag_o),
  .file_group_o(file_group_o), .file_format_o(file_format_o),
  .ecc_type_o(ecc_type_o));

// File: dv/card_specific_data_register_tb.sv
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module card_specific_data_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] DSZ = 12'h5a3;
  logic clk_sys_i = 1'b0;
  logic rst_i, blank_load_i, read_req_i, prog_i, valid, done, ok, locked;
  logic tp, pp, cf, fg, lk;
  logic [1:0] ff, et, sts, pst;
  logic [127:0] pdata, rdata, img;
  logic [14:0] st;
  logic [15:0] lfsr = 16'h4c34;
  int err_total = 0;
  int check_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  card_host_model u_card_host_model (.clk_sys_i(clk_sys_i),
    .read_req_o(read_req_i), .prog_o(prog_i), .data_o(pdata),
    .read_data_i(rdata), .read_valid_i(valid), .program_done_i(done),
    .program_status_i(pst));
  card_specific_data_register #(.DEVICE_SIZE(DSZ))
    u_card_specific_data_register (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .blank_load_i(blank_load_i), .read_req_i(read_req_i),
    .program_card_specific_i(prog_i), .program_data_i(pdata),
    .read_data_o(rdata), .read_valid_o(valid), .program_done_o(done),
    .program_status_o(pst), .once_locked_o(lk), .temp_protect_o(tp),
    .perm_protect_o(pp), .copy_flag_o(cf), .file_group_o(fg),
    .file_format_o(ff), .ecc_type_o(et));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt
  function automatic logic [127:0] exp_image(input logic [14:0] s);
    return {8'hd0, 24'h4f0132, 12'h0f5, 4'h9, 4'h0, 2'h0, DSZ, 15'h7fff,
            16'hffff, 2'h0, 3'h2, 4'h9, 1'h0, 4'h0, 1'h0, s, 1'h1};
  endfunction : exp_image
  task automatic test_done;
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic check_read;
    logic [127:0] d;
    u_card_host_model.xfer(1'b0, '0, d, ok, sts);
    `CHK("valid", 1'b1, ok)
    `CHK("image", exp_image(st), d)
    `CHK("views", st[14:7], {fg, cf, pp, tp, ff, et})
    `CHK("lock", locked, lk)
  endtask : check_read
  task automatic prog_chk(input logic [127:0] p);
    logic [127:0] x;
    logic [1:0] es;
    x = p ^ exp_image(st);
    es = 2'h0;
    if ((x & ~128'hfffe) != '0)
      es = 2'h1;
    else if (locked && (x & card_specific_data_pkg::ONCE_MASK) != '0)
      es = 2'h2;
    u_card_host_model.xfer(1'b1, p, img, ok, sts);
    `CHK("done", 1'b1, ok)
    `CHK("status", es, sts)
    if (es == 2'h0) begin
      st = p[15:1];
      locked = 1'b1;
    end
    check_read();
  endtask : prog_chk
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    test_done();
  end
  initial begin
    rst_i = 1'b1;
    blank_load_i = 1'b0;
    st = '0;
    locked = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    blank_load_i = 1'b1;
    @(negedge clk_sys_i);
    blank_load_i = 1'b0;
    check_read();
    prog_chk(exp_image(st) ^ 128'h1);
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      img = exp_image(st);
      if (i == 12) begin
        // store must outlive a reset taken mid-run
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        check_read();
      end
      if (i % 3 == 0)
        prog_chk(img ^ (128'h1 << (16 + lfsr % 112)));
      else if (i % 3 == 1)
        prog_chk({img[127:16], lfsr[14:0], 1'b1});
      else
        prog_chk({img[127:16], (st & 15'h7600) | (lfsr[14:0] & 15'h09ff),
                  1'b1});
    end
    test_done();
  end
endmodule : card_specific_data_register_tb

// File: hdl/card_specific_data_pkg.sv
package card_specific_data_pkg;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int REG_W = 128;
  localparam int FIELD_LO = 1;
  localparam int FIELD_HI = 15;
  localparam int FIELD_W = 15;

  // ***************************************************************
  // read-only field values
  // ***************************************************************
  localparam logic [1:0] STRUCTURE_VAL = 2'h3;
  localparam logic [3:0] SPEC_VERSION_VAL = 4'h4;
  localparam logic [1:0] RSVD_121_VAL = 2'h0;
  localparam logic [7:0] READ_ACCESS_TIME_BASE_VAL = 8'h4f;
  localparam logic [7:0] READ_ACCESS_CLOCK_TERM_VAL = 8'h01;
  localparam logic [7:0] BUS_SPEED_VAL = 8'h32;
  localparam logic [11:0] COMMAND_CLASSES_VAL = 12'h0f5;
  localparam logic [3:0] READ_BLOCK_LENGTH_CODE_VAL = 4'h9;
  localparam logic READ_PARTIAL_ALLOWED_VAL = 1'h0;
  localparam logic WRITE_MISALIGN_VAL = 1'h0;
  localparam logic READ_MISALIGN_VAL = 1'h0;
  localparam logic DRIVER_STAGE_PRESENT_VAL = 1'h0;
  localparam logic [1:0] RSVD_75_VAL = 2'h0;
  localparam logic [11:0] DEVICE_SIZE_SLOT = 12'h000;
  localparam logic [2:0] CURRENT_CODE_VAL = 3'h7;
  localparam logic [2:0] SIZE_MULT_VAL = 3'h7;
  localparam logic [4:0] ERASE_GROUP_COUNT_VAL = 5'h1f;
  localparam logic [4:0] ERASE_GROUP_FACTOR_VAL = 5'h1f;
  localparam logic [4:0] PROTECT_GROUP_SPAN_VAL = 5'h1f;
  localparam logic PROTECT_GROUP_ON_VAL = 1'h1;
  localparam logic [1:0] DEFAULT_ECC_VAL = 2'h0;
  localparam logic [2:0] WRITE_SPEED_FACTOR_VAL = 3'h2;
  localparam logic [3:0] WRITE_BLOCK_LENGTH_CODE_VAL = 4'h9;
  localparam logic WRITE_PARTIAL_ALLOWED_VAL = 1'h0;
  localparam logic [3:0] RSVD_20_VAL = 4'h0;
  localparam logic CONTENT_PROT_VAL = 1'h0;
  localparam logic [14:0] WRITABLE_SLOT = 15'h0000;
  localparam logic ALWAYS_ONE_VAL = 1'h1;

  // fixed image; device size and writable bits are merged in elsewhere
  localparam logic [127:0] FIXED_IMAGE = {
    STRUCTURE_VAL, SPEC_VERSION_VAL, RSVD_121_VAL,
    READ_ACCESS_TIME_BASE_VAL, READ_ACCESS_CLOCK_TERM_VAL, BUS_SPEED_VAL,
    COMMAND_CLASSES_VAL, READ_BLOCK_LENGTH_CODE_VAL,
    READ_PARTIAL_ALLOWED_VAL, WRITE_MISALIGN_VAL, READ_MISALIGN_VAL,
    DRIVER_STAGE_PRESENT_VAL, RSVD_75_VAL, DEVICE_SIZE_SLOT,
    CURRENT_CODE_VAL, CURRENT_CODE_VAL, CURRENT_CODE_VAL, CURRENT_CODE_VAL,
    SIZE_MULT_VAL, ERASE_GROUP_COUNT_VAL, ERASE_GROUP_FACTOR_VAL,
    PROTECT_GROUP_SPAN_VAL, PROTECT_GROUP_ON_VAL, DEFAULT_ECC_VAL,
    WRITE_SPEED_FACTOR_VAL, WRITE_BLOCK_LENGTH_CODE_VAL,
    WRITE_PARTIAL_ALLOWED_VAL, RSVD_20_VAL, CONTENT_PROT_VAL,
    WRITABLE_SLOT, ALWAYS_ONE_VAL};

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int DEVICE_SIZE_LSB = 62;
  localparam int FILE_GROUP_BIT = 15;
  localparam int COPY_BIT = 14;
  localparam int PERM_PROTECT_BIT = 13;
  localparam int TEMP_PROTECT_BIT = 12;
  localparam int FILE_FORMAT_LSB = 10;
  localparam int ECC_TYPE_LSB = 8;
  localparam int CHECK_CODE_LSB = 1;

  // ***************************************************************
  // access class masks
  // ***************************************************************
  localparam logic [127:0] ONCE_MASK = 128'hec00;
  localparam logic [127:0] ERASABLE_MASK = 128'h13fe;
  localparam logic [127:0] WRITABLE_MASK = ONCE_MASK | ERASABLE_MASK;

  // blank state loaded at manufacture
  localparam logic [14:0] BLANK_FIELDS = 15'h0000;

  // ***************************************************************
  // answer codes of a program command
  // ***************************************************************
  typedef enum logic [1:0] {
    PROG_OK = 2'b00,
    PROG_READ_ONLY = 2'b01,
    PROG_ONCE_USED = 2'b10
  } program_status_t;

endpackage : card_specific_data_pkg

// File: hdl/card_specific_data_register.sv
// How it works
// - Only write- or erase-marked fields change, by a program command.
// - Read access time base reads 4Fh in bits 119:112.
// - Clock-dependent access term reads 01h in 111:104, 100-clock units.
// - Bus frequency code reads 32h in bits 103:96.
// - Read block length code reads 9h in bits 83:80.
// - Bit 79 reads zero: no partial-block reads.
// - Bit 76 reads zero: no driver stage register.
// - Erase group count and factor each read 1Fh at 46:42 and 41:37.
// - Write-protect group span reads 1Fh in bits 36:32.
// - Bit 31 reads one: group write protection is available.
// - Write block length code reads 9h in bits 25:22.
// - Bit 21 reads zero: no partial-block writes.
// - Once-only fields take one program and are read-only afterwards.
// - Rewritable fields survive power cycles, reset pin and reset command.
// - Reserved positions always read zero.
module card_specific_data_register #(
  parameter logic [11:0] DEVICE_SIZE = 12'hfff
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic blank_load_i,
  input wire logic read_req_i,
  input wire logic program_card_specific_i,
  input wire logic [127:0] program_data_i,
  output logic [127:0] read_data_o,
  output logic read_valid_o,
  output logic program_done_o,
  output logic [1:0] program_status_o,
  output logic once_locked_o,
  output logic temp_protect_o,
  output logic perm_protect_o,
  output logic copy_flag_o,
  output logic file_group_o,
  output logic [1:0] file_format_o,
  output logic [1:0] ecc_type_o
);

  // ***************************************************************
  // nonvolatile field store
  // ***************************************************************
  // bits 15:1 of the image; index 0 of fields_r is image bit 1
  logic [14:0] fields_r;
  logic [14:0] fields_nxt;
  logic once_locked_r;
  logic once_locked_nxt;

  // ***************************************************************
  // image assembly
  // ***************************************************************
  logic [127:0] device_size_part;
  logic [127:0] fields_part;
  logic [127:0] image;

  assign device_size_part = {116'h0, DEVICE_SIZE}
                            << card_specific_data_pkg::DEVICE_SIZE_LSB;
  assign fields_part = {112'h0, fields_r, 1'b0};
  // fixed values and reserved zeros come from one constant image
  assign image = card_specific_data_pkg::FIXED_IMAGE |
                 device_size_part |
                 fields_part;

  // ***************************************************************
  // program check
  // ***************************************************************
  program_check_if chk ();

  assign chk.stored = image;
  assign chk.proposed = program_data_i;
  assign chk.once_locked = once_locked_r;

  program_field_check u_check (
    .chk(chk.judge)
  );

  logic do_write;
  assign do_write = program_card_specific_i && chk.accept;

  always_comb begin
    fields_nxt = fields_r;
    if (do_write) begin
      fields_nxt = program_data_i[card_specific_data_pkg::FIELD_HI:
                                  card_specific_data_pkg::FIELD_LO];
    end
  end

  // the first accepted program burns every once-only field at once, as
  // the command always carries the whole image
  always_comb begin
    once_locked_nxt = once_locked_r;
    if (do_write) begin
      once_locked_nxt = 1'b1;
    end
  end

  // ***************************************************************
  // store update
  // ***************************************************************
  // rst_i stands for the reset pin and the reset command: the store is
  // deliberately left alone by it and only a blank load clears it
  always_ff @(posedge clk_sys_i) begin
    if (blank_load_i) begin
      fields_r <= card_specific_data_pkg::BLANK_FIELDS;
    end else begin
      fields_r <= fields_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (blank_load_i) begin
      once_locked_r <= 1'b0;
    end else begin
      once_locked_r <= once_locked_nxt;
    end
  end

  // ***************************************************************
  // read answer
  // ***************************************************************
  // a read in the same cycle as a program returns the old image
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      read_data_o <= 128'h0;
      read_valid_o <= 1'b0;
    end else begin
      read_valid_o <= read_req_i;
      if (read_req_i) begin
        read_data_o <= image;
      end
    end
  end

  // ***************************************************************
  // program answer
  // ***************************************************************
  card_specific_data_pkg::program_status_t status_nxt;

  always_comb begin
    if (chk.read_only_hit) begin
      status_nxt = card_specific_data_pkg::PROG_READ_ONLY;
    end else if (chk.once_hit) begin
      status_nxt = card_specific_data_pkg::PROG_ONCE_USED;
    end else begin
      status_nxt = card_specific_data_pkg::PROG_OK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      program_done_o <= 1'b0;
      program_status_o <= card_specific_data_pkg::PROG_OK;
    end else begin
      program_done_o <= program_card_specific_i;
      if (program_card_specific_i) begin
        program_status_o <= status_nxt;
      end
    end
  end

  // ***************************************************************
  // field views for the rest of the device
  // ***************************************************************
  // these follow the store one cycle late; protection therefore starts
  // the cycle after program_done_o
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      temp_protect_o <= 1'b0;
      perm_protect_o <= 1'b0;
    end else begin
      temp_protect_o <= image[card_specific_data_pkg::TEMP_PROTECT_BIT];
      perm_protect_o <= image[card_specific_data_pkg::PERM_PROTECT_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      copy_flag_o <= 1'b0;
      file_group_o <= 1'b0;
      file_format_o <= 2'h0;
      ecc_type_o <= 2'h0;
      once_locked_o <= 1'b0;
    end else begin
      copy_flag_o <= image[card_specific_data_pkg::COPY_BIT];
      file_group_o <= image[card_specific_data_pkg::FILE_GROUP_BIT];
      file_format_o <= image[card_specific_data_pkg::FILE_FORMAT_LSB +: 2];
      ecc_type_o <= image[card_specific_data_pkg::ECC_TYPE_LSB +: 2];
      once_locked_o <= once_locked_r;
    end
  end

endmodule : card_specific_data_register

// File: hdl/program_check_if.sv
interface program_check_if;
  logic [127:0] stored;
  logic [127:0] proposed;
  logic once_locked;
  logic read_only_hit;
  logic once_hit;
  logic accept;

  modport judge (
    input stored,
    input proposed,
    input once_locked,
    output read_only_hit,
    output once_hit,
    output accept
  );

  modport owner (
    output stored,
    output proposed,
    output once_locked,
    input read_only_hit,
    input once_hit,
    input accept
  );
endinterface : program_check_if

// File: hdl/program_field_check.sv
module program_field_check (
  program_check_if.judge chk
);

  // ***************************************************************
  // masked difference between two images
  // ***************************************************************
  function automatic logic differs(input logic [127:0] mask,
                                   input logic [127:0] a,
                                   input logic [127:0] b);
    differs = |((a ^ b) & mask);
  endfunction : differs

  // ***************************************************************
  // verdict
  // ***************************************************************
  always_comb begin
    // any bit outside the writable classes must come back unchanged
    chk.read_only_hit = differs(~card_specific_data_pkg::WRITABLE_MASK,
                                chk.stored, chk.proposed);
    // once-only fields may change only while still blank
    chk.once_hit = chk.once_locked &&
                   differs(card_specific_data_pkg::ONCE_MASK,
                           chk.stored, chk.proposed);
    chk.accept = !chk.read_only_hit && !chk.once_hit;
  end

endmodule : program_field_check
